// >>> src/secr_cfg.svh
// register offsets, field positions and reset values for the switch config bank
`ifndef SECR_CFG_SVH
`define SECR_CFG_SVH
`define SECR_OFF_NSLAT      12'h234
`define SECR_OFF_SSHDR      12'h240
`define SECR_OFF_SSCAP      12'h244
`define SECR_OFF_SSCTL1     12'h248
`define SECR_OFF_SSCTL2     12'h24C
`define SECR_OFF_LSDBG      12'h33C
`define SECR_OFF_HPDBG      12'h340
`define SECR_OFF_MBCTL      12'h344
`define SECR_SSHDR_VAL      32'h0001001E
`define SECR_CAP_L11_POS    1
`define SECR_CAP_AL11_POS   3
`define SECR_CAP_SS_POS     4
`define SECR_CAP_RST        5'h12
`define SECR_LLDBG_RST      16'h0004
`define SECR_MB_EN_POS      0
`define SECR_MB_PECDIS_POS  9
`define SECR_MB_PECF_POS    29
`define SECR_MB_UNSUP_POS   30
`define SECR_ADDR_HI_RST    4'hD
`endif

// >>> src/secr_pkg.sv
// types shared by the switch config bank
package secr_pkg;
    typedef enum logic [1:0] {
        SECR_ST_RESET = 2'b00,
        SECR_ST_STRAP = 2'b01,
        SECR_ST_RUN   = 2'b11
    } secr_state_t;
endpackage

// >>> src/secr_regs.sv
// configuration register bank: latency, L1 substates, debug words, management control
`timescale 1ns/1ps
`include "secr_cfg.svh"
module secr_regs (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // configuration space access
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_ack,
    // default load from management bus or eeprom
    input  wire logic        ld_cap,
    input  wire logic [2:0]  ld_cap_val,
    input  wire logic        ld_lsdbg,
    input  wire logic [7:0]  ld_lsdbg_val,
    input  wire logic        ld_hpdbg,
    input  wire logic [31:0] ld_hpdbg_val,
    // management bus events and straps
    input  wire logic        pec_fail_ev,
    input  wire logic        unsup_cmd_ev,
    input  wire logic [2:0]  addr_strap,
    // control outputs
    output logic [9:0]       ns_lat_value,
    output logic [2:0]       ns_lat_scale,
    output logic             pm_l11_en,
    output logic             aspm_l11_en,
    output logic             smbus_mode,
    output logic [6:0]       slave_addr,
    output logic             pec_check_dis
);

    // strap synchroniser and capture state
    logic [2:0] strap_s1_q;
    logic [2:0] strap_s2_q;
    secr_pkg::secr_state_t st_q;
    secr_pkg::secr_state_t st_d;

    // register state
    logic [9:0]  nslat_val_q;
    logic [2:0]  nslat_scl_q;
    logic [2:0]  cap_q;      // {ss, aspm l1.1, pm l1.1}
    logic        l11_en_q;
    logic        al11_en_q;
    logic [7:0]  lsdbg_q;
    logic [15:0] hpdbg_q;
    logic [15:0] lldbg_q;
    logic        mb_en_q;
    logic [6:0]  mb_addr_q;
    logic        pec_dis_q;
    logic        pec_fail_q;
    logic        unsup_q;
    logic        ack_q;
    logic [31:0] rdata_q;

    // capability reset image, only bits 4, 3 and 1 are live
    localparam logic [4:0] cap_rst_img = `SECR_CAP_RST;

    // byte lane merge helper
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // address decode
    wire sel_nslat = cfg_addr == `SECR_OFF_NSLAT;
    wire sel_sshdr = cfg_addr == `SECR_OFF_SSHDR;
    wire sel_sscap = cfg_addr == `SECR_OFF_SSCAP;
    wire sel_ctl1  = cfg_addr == `SECR_OFF_SSCTL1;
    wire sel_ctl2  = cfg_addr == `SECR_OFF_SSCTL2;
    wire sel_lsdbg = cfg_addr == `SECR_OFF_LSDBG;
    wire sel_hpdbg = cfg_addr == `SECR_OFF_HPDBG;
    wire sel_mbctl = cfg_addr == `SECR_OFF_MBCTL;

    // current register images
    wire [31:0] img_nslat = {3'h0, nslat_scl_q, nslat_val_q, 16'h0000};
    wire [31:0] img_sscap = {27'h0, cap_q[2], cap_q[1], 1'b0, cap_q[0], 1'b0};
    wire [31:0] img_ctl1  = {28'h0, al11_en_q, 1'b0, l11_en_q, 1'b0};
    wire [31:0] img_mbctl = {1'b0, unsup_q, pec_fail_q, 19'h0, pec_dis_q, 1'b0,
                             mb_addr_q, mb_en_q};
    wire [31:0] wr_nslat  = merge(img_nslat, cfg_wdata, cfg_be);
    wire [31:0] wr_ctl1   = merge(img_ctl1, cfg_wdata, cfg_be);
    wire [31:0] wr_mbctl  = merge(img_mbctl, cfg_wdata, cfg_be);
    // write-one-clear mask only over enabled lanes
    wire [31:0] w1c_mask  = cfg_wdata & {{8{cfg_be[3]}}, {8{cfg_be[2]}},
                                         {8{cfg_be[1]}}, {8{cfg_be[0]}}};
    wire do_nslat = cfg_wr && sel_nslat;
    wire do_ctl1  = cfg_wr && sel_ctl1;
    wire do_mbctl = cfg_wr && sel_mbctl;
    wire clr_pecf = do_mbctl && w1c_mask[`SECR_MB_PECF_POS];
    wire clr_unsup = do_mbctl && w1c_mask[`SECR_MB_UNSUP_POS];

    // read mux; unmapped and reserved read zero
    wire [31:0] rd_mux = sel_nslat ? img_nslat :
                         sel_sshdr ? `SECR_SSHDR_VAL :
                         sel_sscap ? img_sscap :
                         sel_ctl1  ? img_ctl1 :
                         sel_ctl2  ? 32'h00000000 :
                         sel_lsdbg ? {24'h000000, lsdbg_q} :
                         sel_hpdbg ? {lldbg_q, hpdbg_q} :
                         sel_mbctl ? img_mbctl : 32'h00000000;

    // strap capture sequencing
    always_comb begin
        case (st_q)
            secr_pkg::SECR_ST_RESET: st_d = secr_pkg::SECR_ST_STRAP;
            secr_pkg::SECR_ST_STRAP: st_d = secr_pkg::SECR_ST_RUN;
            secr_pkg::SECR_ST_RUN:   st_d = secr_pkg::SECR_ST_RUN;
            default:                 st_d = secr_pkg::SECR_ST_RESET;
        endcase
    end

    // two-flop strap synchroniser, free running so straps settle during reset
    always_ff @(posedge mclk) begin
        strap_s1_q <= addr_strap;
        strap_s2_q <= strap_s1_q;
    end

    // strap capture state register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= secr_pkg::SECR_ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // latency and substates control
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nslat_val_q <= 10'h000;
            nslat_scl_q <= 3'h0;
            l11_en_q    <= 1'b0;
            al11_en_q   <= 1'b0;
        end else begin
            if (do_nslat) begin
                nslat_val_q <= wr_nslat[25:16];
                nslat_scl_q <= wr_nslat[28:26];
            end
            if (do_ctl1) begin
                l11_en_q  <= wr_ctl1[`SECR_CAP_L11_POS];
                al11_en_q <= wr_ctl1[`SECR_CAP_AL11_POS];
            end
        end
    end

    // capability and debug words: management loads only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cap_q   <= {cap_rst_img[`SECR_CAP_SS_POS], cap_rst_img[`SECR_CAP_AL11_POS],
                        cap_rst_img[`SECR_CAP_L11_POS]};
            lsdbg_q <= 8'h00;
            hpdbg_q <= 16'h0000;
            lldbg_q <= `SECR_LLDBG_RST;
        end else begin
            if (ld_cap) begin
                cap_q <= ld_cap_val;
            end
            if (ld_lsdbg) begin
                lsdbg_q <= ld_lsdbg_val;
            end
            if (ld_hpdbg) begin
                hpdbg_q <= ld_hpdbg_val[15:0];
                lldbg_q <= ld_hpdbg_val[31:16];
            end
        end
    end

    // management bus control register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mb_en_q    <= 1'b1;
            mb_addr_q  <= {`SECR_ADDR_HI_RST, 3'h0};
            pec_dis_q  <= 1'b1;
            pec_fail_q <= 1'b0;
            unsup_q    <= 1'b0;
        end else begin
            if (st_q == secr_pkg::SECR_ST_STRAP) begin
                mb_addr_q[2:0] <= strap_s2_q;
            end else if (do_mbctl) begin
                mb_addr_q <= wr_mbctl[7:1];
            end
            if (do_mbctl) begin
                mb_en_q   <= wr_mbctl[`SECR_MB_EN_POS];
                pec_dis_q <= wr_mbctl[`SECR_MB_PECDIS_POS];
            end
            // event set wins over a simultaneous clear
            pec_fail_q <= pec_fail_ev || (pec_fail_q && !clr_pecf);
            unsup_q    <= unsup_cmd_ev || (unsup_q && !clr_unsup);
        end
    end

    // read data and acknowledge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q   <= cfg_wr || cfg_rd;
            rdata_q <= cfg_rd ? rd_mux : 32'h00000000;
        end
    end

    // outputs
    assign cfg_rdata     = rdata_q;
    assign cfg_ack       = ack_q;
    assign ns_lat_value  = nslat_val_q;
    assign ns_lat_scale  = nslat_scl_q;
    assign pm_l11_en     = l11_en_q;
    assign aspm_l11_en   = al11_en_q;
    assign smbus_mode    = mb_en_q;
    assign slave_addr    = mb_addr_q;
    assign pec_check_dis = pec_dis_q;

    // assertions
    property p_nslat_wr;
        @(posedge mclk) disable iff (!rst_n)
        (do_nslat && cfg_be[2]) |=> ns_lat_value[7:0] == $past(cfg_wdata[23:16]);
    endproperty
    a_nslat_wr: assert property (p_nslat_wr) else $error("latency value not written");

    property p_scale_hold;
        @(posedge mclk) disable iff (!rst_n)
        !do_nslat |=> $stable(ns_lat_scale);
    endproperty
    a_scale_hold: assert property (p_scale_hold) else $error("latency scale changed");

    property p_hdr;
        @(posedge mclk) disable iff (!rst_n)
        (cfg_rd && sel_sshdr) |=> cfg_ack && cfg_rdata == 32'h0001001E;
    endproperty
    a_hdr: assert property (p_hdr) else $error("header read wrong");

    property p_cap_ro;
        @(posedge mclk) disable iff (!rst_n)
        (!ld_cap) |=> $stable(cap_q);
    endproperty
    a_cap_ro: assert property (p_cap_ro) else $error("capability changed");

    property p_ctl1;
        @(posedge mclk) disable iff (!rst_n)
        (do_ctl1 && cfg_be[0]) |=> pm_l11_en == $past(cfg_wdata[1])
                                   && aspm_l11_en == $past(cfg_wdata[3]);
    endproperty
    a_ctl1: assert property (p_ctl1) else $error("control-1 enables wrong");

    property p_ctl2;
        @(posedge mclk) disable iff (!rst_n)
        (cfg_rd && sel_ctl2) |=> cfg_rdata == 32'h00000000;
    endproperty
    a_ctl2: assert property (p_ctl2) else $error("control-2 not zero");

    property p_strap;
        @(posedge mclk) disable iff (!rst_n)
        (st_q == secr_pkg::SECR_ST_STRAP) |=> slave_addr[2:0] == $past(strap_s2_q);
    endproperty
    a_strap: assert property (p_strap) else $error("strap address not captured");

    property p_pec_set;
        @(posedge mclk) disable iff (!rst_n)
        pec_fail_ev |=> pec_fail_q;
    endproperty
    a_pec_set: assert property (p_pec_set) else $error("pec fail flag lost");

    property p_unsup_clr;
        @(posedge mclk) disable iff (!rst_n)
        (do_mbctl && cfg_be[3] && cfg_wdata[30] && !unsup_cmd_ev) |=> !unsup_q;
    endproperty
    a_unsup_clr: assert property (p_unsup_clr) else $error("flag not cleared");

    property p_w0_keep;
        @(posedge mclk) disable iff (!rst_n)
        (do_mbctl && !cfg_wdata[29] && pec_fail_q) |=> pec_fail_q;
    endproperty
    a_w0_keep: assert property (p_w0_keep) else $error("write zero cleared flag");

    property p_scale_wr;
        @(posedge mclk) disable iff (!rst_n)
        (do_nslat && cfg_be[3]) |=> ns_lat_scale == $past(cfg_wdata[28:26]);
    endproperty
    a_scale_wr: assert property (p_scale_wr) else $error("latency scale not written");

    property p_cap_ld;
        @(posedge mclk) disable iff (!rst_n)
        ld_cap |=> cap_q == $past(ld_cap_val);
    endproperty
    a_cap_ld: assert property (p_cap_ld) else $error("capability load lost");

    property p_lsdbg_ro;
        @(posedge mclk) disable iff (!rst_n)
        (!ld_lsdbg) |=> $stable(lsdbg_q);
    endproperty
    a_lsdbg_ro: assert property (p_lsdbg_ro) else $error("link state word changed");

    property p_hpdbg_ro;
        @(posedge mclk) disable iff (!rst_n)
        (!ld_hpdbg) |=> $stable(hpdbg_q);
    endproperty
    a_hpdbg_ro: assert property (p_hpdbg_ro) else $error("hot insertion word changed");

    property p_lldbg_ro;
        @(posedge mclk) disable iff (!rst_n)
        (!ld_hpdbg) |=> $stable(lldbg_q);
    endproperty
    a_lldbg_ro: assert property (p_lldbg_ro) else $error("link layer word changed");

    property p_mode_wr;
        @(posedge mclk) disable iff (!rst_n)
        (do_mbctl && cfg_be[0]) |=> smbus_mode == $past(cfg_wdata[0]);
    endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("protocol select wrong");

    property p_addr_wr;
        @(posedge mclk) disable iff (!rst_n)
        (do_mbctl && cfg_be[0] && st_q == secr_pkg::SECR_ST_RUN)
            |=> slave_addr == $past(cfg_wdata[7:1]);
    endproperty
    a_addr_wr: assert property (p_addr_wr) else $error("slave address wrong");

    property p_pecdis_wr;
        @(posedge mclk) disable iff (!rst_n)
        (do_mbctl && cfg_be[1]) |=> pec_check_dis == $past(cfg_wdata[9]);
    endproperty
    a_pecdis_wr: assert property (p_pecdis_wr) else $error("pec disable wrong");

    property p_pec_clr;
        @(posedge mclk) disable iff (!rst_n)
        (do_mbctl && cfg_be[3] && cfg_wdata[29] && !pec_fail_ev) |=> !pec_fail_q;
    endproperty
    a_pec_clr: assert property (p_pec_clr) else $error("pec flag not cleared");

    property p_unsup_set;
        @(posedge mclk) disable iff (!rst_n)
        unsup_cmd_ev |=> unsup_q;
    endproperty
    a_unsup_set: assert property (p_unsup_set) else $error("unsupported flag lost");

    c_flag_set:  cover property (@(posedge mclk) disable iff (!rst_n) unsup_cmd_ev ##1 unsup_q);
    c_flag_clr:  cover property (@(posedge mclk) disable iff (!rst_n) unsup_q ##1 !unsup_q);
    c_mode_i2c:  cover property (@(posedge mclk) disable iff (!rst_n) !smbus_mode);
    c_cap_load:  cover property (@(posedge mclk) disable iff (!rst_n) ld_cap ##1 !cap_q[0]);

endmodule

// >>> tb/secr_mgmt_host.sv
// management host model: default loads and bus event pulses
`timescale 1ns/1ps
module secr_mgmt_host (
    // clock
    input  wire logic        mclk,
    // default loads
    output logic             ld_cap,
    output logic [2:0]       ld_cap_val,
    output logic             ld_lsdbg,
    output logic [7:0]       ld_lsdbg_val,
    output logic             ld_hpdbg,
    output logic [31:0]      ld_hpdbg_val,
    // bus events
    output logic             pec_fail_ev,
    output logic             unsup_cmd_ev
);
    // idle state, values scrambled
    initial begin
        {ld_cap, ld_lsdbg, ld_hpdbg, pec_fail_ev, unsup_cmd_ev} = 5'h00;
        {ld_cap_val, ld_lsdbg_val, ld_hpdbg_val} = 43'h5A5A5A5A5A5;
    end
    // one-cycle load pulses, value inverted once released
    task automatic load(input logic [2:0] c, input logic [7:0] l, input logic [31:0] h);
        @(negedge mclk);
        ld_cap = 1'b1;
        ld_cap_val = c;
        ld_lsdbg = 1'b1;
        ld_lsdbg_val = l;
        ld_hpdbg = 1'b1;
        ld_hpdbg_val = h;
        @(negedge mclk);
        {ld_cap, ld_lsdbg, ld_hpdbg} = 3'h0;
        ld_cap_val = ~c;
        ld_lsdbg_val = ~l;
        ld_hpdbg_val = ~h;
    endtask
    // one-cycle event pulses
    task automatic events(input logic pec, input logic unsup);
        @(negedge mclk);
        pec_fail_ev = pec;
        unsup_cmd_ev = unsup;
        @(negedge mclk);
        {pec_fail_ev, unsup_cmd_ev} = 2'h0;
    endtask
endmodule

// >>> tb/tb_switch_ext_config_regs.sv
// self-checking bench for the switch config register bank
`timescale 1ns/1ps
`include "secr_cfg.svh"
module tb_switch_ext_config_regs;
    logic        mclk, rst_n, cfg_wr, cfg_rd, cfg_ack, ld_cap, ld_lsdbg, ld_hpdbg;
    logic        pec_fail_ev, unsup_cmd_ev, pm_l11_en, aspm_l11_en, smbus_mode, pec_check_dis;
    logic [11:0] cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, ld_hpdbg_val;
    logic [2:0]  ld_cap_val, addr_strap, ns_lat_scale;
    logic [7:0]  ld_lsdbg_val;
    logic [9:0]  ns_lat_value;
    logic [6:0]  slave_addr;
    int          n_errors, n_tests, cyc;
    // reset images, strap 101 gives address 1101101
    logic [11:0] ra [9] = '{12'h234, 12'h240, 12'h244, 12'h248, 12'h24C, 12'h33C,
                            12'h340, 12'h344, 12'h100};
    logic [31:0] rv [9] = '{32'h0, 32'h0001001E, 32'h12, 32'h0, 32'h0, 32'h0,
                            32'h00040000, 32'h000002DB, 32'h0};
    secr_regs DUT (.mclk(mclk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .ld_cap(ld_cap), .ld_cap_val(ld_cap_val), .ld_lsdbg(ld_lsdbg),
        .ld_lsdbg_val(ld_lsdbg_val), .ld_hpdbg(ld_hpdbg), .ld_hpdbg_val(ld_hpdbg_val),
        .pec_fail_ev(pec_fail_ev), .unsup_cmd_ev(unsup_cmd_ev), .addr_strap(addr_strap),
        .ns_lat_value(ns_lat_value), .ns_lat_scale(ns_lat_scale), .pm_l11_en(pm_l11_en),
        .aspm_l11_en(aspm_l11_en), .smbus_mode(smbus_mode), .slave_addr(slave_addr),
        .pec_check_dis(pec_check_dis));
    secr_mgmt_host host (.mclk(mclk), .ld_cap(ld_cap), .ld_cap_val(ld_cap_val),
        .ld_lsdbg(ld_lsdbg), .ld_lsdbg_val(ld_lsdbg_val), .ld_hpdbg(ld_hpdbg),
        .ld_hpdbg_val(ld_hpdbg_val), .pec_fail_ev(pec_fail_ev), .unsup_cmd_ev(unsup_cmd_ev));
    // clock, 10 ns period
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            end_sim();
        end
    end
    // compare and report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic end_sim();
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one write access, ack expected next cycle
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        @(negedge mclk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        cfg_be = be;
        @(negedge mclk);
        cfg_wr = 1'b0;
        cfg_wdata = ~d;
        chk(32'(cfg_ack), 32'h1);
    endtask
    // one read access and data compare
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(negedge mclk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge mclk);
        cfg_rd = 1'b0;
        chk(32'(cfg_ack), 32'h1);
        chk(cfg_rdata, e);
    endtask
    // reset held 20 cycles, then defaults read back
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
        chk(32'({pec_check_dis, smbus_mode, slave_addr}), 32'h1ED);
    endtask
    // main sequence
    initial begin
        {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = 49'h0;
        addr_strap = 3'h5;
        do_reset();
        wr(12'h234, 32'hFFFFFFFF, 4'hF);
        rd(12'h234, 32'h1FFF0000);
        chk(32'({ns_lat_scale, ns_lat_value}), 32'h1FFF);
        wr(12'h234, 32'h0, 4'h4);
        rd(12'h234, 32'h1F000000);
        wr(12'h248, 32'hFFFFFFFF, 4'hF);
        rd(12'h248, 32'hA);
        chk(32'({pm_l11_en, aspm_l11_en}), 32'h3);
        // read-only places ignore writes
        for (int i = 1; i < 9; i++) begin
            if (i != 3 && i != 7) begin
                wr(ra[i], 32'hFFFFFFFF, 4'hF);
                rd(ra[i], rv[i]);
            end
        end
        wr(12'h344, 32'h00000054, 4'hF);
        rd(12'h344, 32'h54);
        chk(32'({pec_check_dis, smbus_mode, slave_addr}), 32'h2A);
        host.load(3'h2, 8'hA5, 32'h12345678);
        rd(12'h244, 32'h08);
        rd(12'h33C, 32'hA5);
        rd(12'h340, 32'h12345678);
        host.events(1'b1, 1'b0);
        rd(12'h344, 32'h20000054);
        host.events(1'b0, 1'b1);
        rd(12'h344, 32'h60000054);
        wr(12'h344, 32'h00000054, 4'hF);
        rd(12'h344, 32'h60000054);
        // flags sit in lane 3, so a write with that lane off clears nothing
        wr(12'h344, 32'h60000054, 4'h7);
        rd(12'h344, 32'h60000054);
        wr(12'h344, 32'h20000054, 4'hF);
        rd(12'h344, 32'h40000054);
        wr(12'h344, 32'h40000054, 4'hF);
        rd(12'h344, 32'h54);
        // second reset mid-run restores every default
        do_reset();
        end_sim();
    end
endmodule
